// [tfo_pkg.sv]
// Package for the T1 transmit formatter: register map, field positions,
// reset values, frame geometry and line-state encodings.
// Assumes an APB slave with 32-bit data and byte addresses.
package tfo_pkg;

  // Register byte offsets
  localparam logic [7:0] TFO_OFF_CTRL_ONE   = 8'h00;
  localparam logic [7:0] TFO_OFF_CTRL_TWO   = 8'h04;
  localparam logic [7:0] TFO_OFF_COMMON     = 8'h08;
  localparam logic [7:0] TFO_OFF_FACILITY   = 8'h0C;
  localparam logic [7:0] TFO_OFF_STATUS     = 8'h10;

  // Reset values
  localparam logic [7:0] TFO_RST_CTRL_ONE   = 8'h00;
  localparam logic [7:0] TFO_RST_CTRL_TWO   = 8'h40;
  localparam logic [7:0] TFO_RST_COMMON     = 8'h00;
  localparam logic [7:0] TFO_RST_FACILITY   = 8'h00;

  // Control register one fields
  localparam int TFO_B1_YELLOW    = 0;
  localparam int TFO_B1_CRC_PASS  = 5;
  localparam int TFO_B1_FBIT_PASS = 6;
  localparam int TFO_B1_JAPAN_CRC = 7;
  localparam logic [7:0] TFO_MASK_CTRL_ONE = 8'hE1;

  // Control register two fields
  localparam int TFO_B2_B7ZS      = 0;
  localparam int TFO_B2_D4YEL_FMT = 2;
  localparam int TFO_B2_BURST     = 3;
  localparam int TFO_B2_PERIODIC  = 4;
  localparam int TFO_B2_FS_INS    = 6;
  localparam int TFO_B2_B8ZS      = 7;
  localparam logic [7:0] TFO_MASK_CTRL_TWO = 8'hDD;

  // Common control: framing mode select
  localparam int TFO_BC_ESF       = 0;
  localparam logic [7:0] TFO_MASK_COMMON = 8'h01;

  // Frame geometry
  localparam int TFO_CHANNELS     = 24;
  localparam int TFO_D4_FRAMES    = 12;
  localparam int TFO_ESF_FRAMES   = 24;
  localparam int TFO_PERIOD_BITS  = 128;
  localparam logic [1:0] TFO_BURST_LEN = 2'd3;

  // Framing patterns, first-sent bit in the MSB
  localparam logic [5:0] TFO_FS_PATTERN  = 6'b00_1110;
  localparam logic [5:0] TFO_FPS_PATTERN = 6'b00_1011;
  localparam logic [7:0] TFO_IDLE_BYTE   = 8'hFF;

  // CRC6 generator x^6 + x + 1, multiplied-by-x^6 form
  localparam logic [5:0] TFO_CRC_POLY    = 6'h03;

  // B8ZS substitution 000VB0VB, first-sent bit in the MSB
  localparam logic [7:0] TFO_B8ZS_PULSE  = 8'h1B;
  localparam logic [7:0] TFO_B8ZS_VIOL   = 8'h12;

  // Formatter sequence
  typedef enum logic [1:0] {
    TFO_ST_IDLE = 2'b00,
    TFO_ST_FBIT = 2'b01,
    TFO_ST_DATA = 2'b11
  } tfo_state_t;

endpackage

// [tfo_buf2.sv]
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tfo_buf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock_in,
  input  wire logic         rst_in,
  // Fill side
  input  wire logic [W-1:0] wr_data_in,
  input  wire logic         wr_valid_in,
  output logic              wr_ready_out,
  // Drain side
  output logic [W-1:0]      rd_data_out,
  output logic              rd_valid_out,
  input  wire logic         rd_ready_in
);
  logic [1:0]   cnt_q, cnt_d;
  logic [W-1:0] e0_q, e0_d, e1_q, e1_d;
  logic         push, pop;
  logic         rdy_q, rdy_d;

  assign push         = wr_valid_in && (cnt_q != 2'd2);
  assign pop          = rd_ready_in && (cnt_q != 2'd0);
  // Ready is a flop copy of "not full" so the port carries no logic path
  assign wr_ready_out = rdy_q;
  assign rd_valid_out = (cnt_q != 2'd0);
  assign rd_data_out  = e0_q;

  always_comb begin
    cnt_d = cnt_q;
    e0_d  = e0_q;
    e1_d  = e1_q;
    if (pop) begin
      e0_d = e1_q;
    end
    if (push) begin
      // Head slot is written when it is, or is about to be, free
      if (cnt_q == 2'd0 || (cnt_q == 2'd1 && pop)) begin
        e0_d = wr_data_in;
      end else begin
        e1_d = wr_data_in;
      end
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    rdy_d = (cnt_d != 2'd2);
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cnt_q <= 2'd0;
      rdy_q <= 1'b1;
      e0_q  <= '0;
      e1_q  <= '0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      e0_q  <= e0_d;
      e1_q  <= e1_d;
    end
  end
endmodule
`default_nettype wire

// [tfo_crc6.sv]
// Serial CRC6 over one superframe; the finished remainder is held
// for transmission during the following superframe.
// Assumes start marks the first bit of a superframe.
`timescale 1ns/1ps
`default_nettype none
module tfo_crc6 (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // Bit stream
  input  wire logic       bit_in,
  input  wire logic       valid_in,
  input  wire logic       start_in,
  // Result of the previous superframe
  output logic [5:0]      crc_out
);
  import tfo_pkg::*;

  logic [5:0] rem_q, rem_d, hold_q, hold_d;
  logic [5:0] base;
  logic       fb;

  always_comb begin
    base   = start_in ? 6'h00 : rem_q;
    fb     = base[5] ^ bit_in;
    hold_d = start_in ? rem_q : hold_q;
    rem_d  = rem_q;
    if (valid_in) begin
      rem_d = {base[4:0], 1'b0} ^ (fb ? TFO_CRC_POLY : 6'h00);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rem_q  <= 6'h00;
      hold_q <= 6'h00;
    end else begin
      rem_q  <= rem_d;
      hold_q <= hold_d;
    end
  end

  assign crc_out = hold_q;
endmodule
`default_nettype wire

// [tfo_formatter.sv]
// T1 transmit formatter: builds D4 or ESF frames from channel bytes,
// inserts or passes through F and CRC6 bits, applies corruption,
// zero suppression and AMI/B8ZS line coding. APB register slave.
// Assumes one line bit per clock; channel bytes arrive ahead of need.
//
// Summary of operation
// - F-bit pass-through takes F bits from serial input
// - CRC6 variant: standard or Japanese calculation
// - Bit-7 stuffing in all-zero channels when enabled
// - D4 yellow: bit-2 zeros or frame-12 S-bit
// - Burst control rise corrupts next three terminal bits
// - Periodic control corrupts one in 128 terminal bits
// - Fs insertion sources Fs pattern from facility register
// - B8ZS substitution applied when enabled
// - CRC pass-through samples CRC bits from serial input
// - Yellow alarm sent while yellow control is one
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tfo_formatter (
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  // APB slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [7:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // Channel bytes
  input  wire logic [7:0]          chan_data_in,
  input  wire logic                chan_valid_in,
  output logic                     chan_ready_out,
  // Serial pass-through input
  input  wire logic                transmit_serial_input_in,
  // Line side
  output logic                     line_pos_out,
  output logic                     line_neg_out,
  output logic                     frame_sync_out
);
  import tfo_pkg::*;

  // Registers
  logic [7:0]  ctl1_q, ctl1_d, ctl2_q, ctl2_d, com_q, com_d;
  logic [7:0]  fac_q, fac_d, under_q, under_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q, ready_d, err_q, err_d;
  logic        burst_prev_q, burst_prev_d;
  logic        setup, wr_en, known;
  logic [31:0] rd_mux;

  // Formatter state
  tfo_state_t  st_q, st_d;
  logic [2:0]  bit_q, bit_d;
  logic [4:0]  ch_q, ch_d, frm_q, frm_d;
  logic [7:0]  sh_q, sh_d;
  logic [1:0]  burst_q, burst_d;
  logic [6:0]  per_q, per_d;
  logic [3:0]  fdl_q, fdl_d;
  logic        load, esf, yel, fbit, term, corrupt, crc_in, stream_bit;
  logic [7:0]  byte_in;
  logic [2:0]  k;
  logic [5:0]  crc_hold;
  logic [7:0]  buf_data;
  logic        buf_valid;

  // Line coder state
  logic [7:0]  dat_q, dat_d, pul_q, pul_d, vio_q, vio_d, mk_q, mk_d;
  logic        pol_q, pol_d, pos_q, pos_d, neg_q, neg_d, sync_q, sync_d;
  logic [7:0]  win;

  assign esf = com_q[TFO_BC_ESF];
  assign yel = ctl1_q[TFO_B1_YELLOW];

  tfo_buf2 #(.W(8)) u_buf (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .wr_data_in   (chan_data_in),
    .wr_valid_in  (chan_valid_in),
    .wr_ready_out (chan_ready_out),
    .rd_data_out  (buf_data),
    .rd_valid_out (buf_valid),
    .rd_ready_in  (load)
  );

  // APB: one wait state, reply registered
  always_comb begin
    setup  = psel_in && penable_in && !ready_q;
    wr_en  = psel_in && penable_in && ready_q && pwrite_in && !err_q;
    known  = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr_in == TFO_OFF_CTRL_ONE) begin
      rd_mux = {24'h00_0000, ctl1_q};
    end else if (paddr_in == TFO_OFF_CTRL_TWO) begin
      rd_mux = {24'h00_0000, ctl2_q};
    end else if (paddr_in == TFO_OFF_COMMON) begin
      rd_mux = {24'h00_0000, com_q};
    end else if (paddr_in == TFO_OFF_FACILITY) begin
      rd_mux = {24'h00_0000, fac_q};
    end else if (paddr_in == TFO_OFF_STATUS) begin
      rd_mux = {16'h0000, under_q, frm_q, 1'b0, burst_q};
    end else begin
      known = 1'b0;
    end
    ready_d = setup;
    err_d   = setup && !known;
    rdata_d = (setup && !pwrite_in) ? rd_mux : 32'h0000_0000;
    ctl1_d  = ctl1_q;
    ctl2_d  = ctl2_q;
    com_d   = com_q;
    fac_d   = fac_q;
    if (wr_en) begin
      if (paddr_in == TFO_OFF_CTRL_ONE) begin
        ctl1_d = pwdata_in[7:0] & TFO_MASK_CTRL_ONE;
      end else if (paddr_in == TFO_OFF_CTRL_TWO) begin
        ctl2_d = pwdata_in[7:0] & TFO_MASK_CTRL_TWO;
      end else if (paddr_in == TFO_OFF_COMMON) begin
        com_d = pwdata_in[7:0] & TFO_MASK_COMMON;
      end else if (paddr_in == TFO_OFF_FACILITY) begin
        fac_d = pwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctl1_q  <= TFO_RST_CTRL_ONE;
      ctl2_q  <= TFO_RST_CTRL_TWO;
      com_q   <= TFO_RST_COMMON;
      fac_q   <= TFO_RST_FACILITY;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      ctl1_q  <= ctl1_d;
      ctl2_q  <= ctl2_d;
      com_q   <= com_d;
      fac_q   <= fac_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q   <= err_d;
    end
  end

  assign prdata_out  = rdata_q;
  assign pready_out  = ready_q;
  assign pslverr_out = err_q;

  tfo_crc6 u_crc (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .bit_in   (crc_in),
    .valid_in (esf && st_q != TFO_ST_IDLE),
    .start_in (st_q == TFO_ST_FBIT && frm_q == 5'd0),
    .crc_out  (crc_hold)
  );

  // Frame builder
  always_comb begin
    st_d    = st_q;
    bit_d   = bit_q;
    ch_d    = ch_q;
    frm_d   = frm_q;
    sh_d    = sh_q;
    burst_d = burst_q;
    per_d   = per_q;
    fdl_d   = fdl_q;
    under_d = under_q;
    load    = 1'b0;
    fbit    = 1'b1;
    term    = 1'b0;
    k       = 3'd5 - 3'(frm_q >> (esf ? 2 : 1));
    // Standard CRC6 counts every F bit as one
    burst_prev_d = ctl2_q[TFO_B2_BURST];
    if (ctl2_q[TFO_B2_BURST] && !burst_prev_q) begin
      burst_d = TFO_BURST_LEN;
    end
    if (!ctl2_q[TFO_B2_PERIODIC]) begin
      per_d = 7'd0;
    end
    if (!esf) begin
      if (!frm_q[0]) begin
        fbit = !frm_q[1];
        term = 1'b1;
      end else if (yel && ctl2_q[TFO_B2_D4YEL_FMT] &&
                   frm_q == 5'(TFO_D4_FRAMES - 1)) begin
        fbit = 1'b1;
      end else if (ctl2_q[TFO_B2_FS_INS]) begin
        fbit = fac_q[k];
      end else begin
        fbit = TFO_FS_PATTERN[k];
      end
    end else begin
      if (frm_q[1:0] == 2'd3) begin
        fbit = TFO_FPS_PATTERN[k];
        term = 1'b1;
      end else if (frm_q[1:0] == 2'd1) begin
        fbit = ctl1_q[TFO_B1_CRC_PASS] ? transmit_serial_input_in
                                       : crc_hold[k];
      end else begin
        fbit = yel ? fdl_q[3] : 1'b1;
      end
    end
    corrupt = term && (burst_q != 2'd0 ||
              (ctl2_q[TFO_B2_PERIODIC] &&
               per_q == 7'(TFO_PERIOD_BITS - 1)));
    if (ctl1_q[TFO_B1_FBIT_PASS]) begin
      fbit = transmit_serial_input_in;
    end else if (corrupt) begin
      fbit = !fbit;
    end
    byte_in = buf_valid ? buf_data : TFO_IDLE_BYTE;
    if (ctl2_q[TFO_B2_B7ZS] && byte_in == 8'h00) begin
      byte_in[1] = 1'b1;
    end
    if (!esf && yel && !ctl2_q[TFO_B2_D4YEL_FMT]) begin
      byte_in[6] = 1'b0;
    end
    stream_bit = (st_q == TFO_ST_FBIT) ? fbit : sh_q[7];
    crc_in = (st_q == TFO_ST_FBIT && !ctl1_q[TFO_B1_JAPAN_CRC]) ?
             1'b1 : stream_bit;
    case (st_q)
      TFO_ST_IDLE: begin
        st_d  = TFO_ST_FBIT;
        frm_d = 5'd0;
      end
      TFO_ST_FBIT: begin
        st_d  = TFO_ST_DATA;
        bit_d = 3'd0;
        ch_d  = 5'd0;
        load  = 1'b1;
        // Count down only bits that were really inverted
        if (term && burst_q != 2'd0 && !ctl1_q[TFO_B1_FBIT_PASS]) begin
          burst_d = burst_d - 2'd1;
        end
        if (term && ctl2_q[TFO_B2_PERIODIC]) begin
          per_d = per_q + 7'd1;
        end
        if (esf && frm_q[0] == 1'b0) begin
          fdl_d = fdl_q + 4'd1;
        end
      end
      TFO_ST_DATA: begin
        bit_d = bit_q + 3'd1;
        sh_d  = {sh_q[6:0], 1'b0};
        if (bit_q == 3'd7) begin
          if (ch_q == 5'(TFO_CHANNELS - 1)) begin
            st_d  = TFO_ST_FBIT;
            frm_d = (frm_q == 5'(esf ? TFO_ESF_FRAMES - 1
                                     : TFO_D4_FRAMES - 1)) ?
                    5'd0 : frm_q + 5'd1;
          end else begin
            ch_d = ch_q + 5'd1;
            load = 1'b1;
          end
        end
      end
      default: st_d = TFO_ST_IDLE;
    endcase
    if (load) begin
      sh_d = byte_in;
      if (!buf_valid && under_q != 8'hFF) begin
        under_d = under_q + 8'd1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_q         <= TFO_ST_IDLE;
      bit_q        <= 3'd0;
      ch_q         <= 5'd0;
      frm_q        <= 5'd0;
      sh_q         <= 8'h00;
      burst_q      <= 2'd0;
      burst_prev_q <= 1'b0;
      per_q        <= 7'd0;
      fdl_q        <= 4'd0;
      under_q      <= 8'h00;
    end else begin
      st_q         <= st_d;
      bit_q        <= bit_d;
      ch_q         <= ch_d;
      frm_q        <= frm_d;
      sh_q         <= sh_d;
      burst_q      <= burst_d;
      burst_prev_q <= burst_prev_d;
      per_q        <= per_d;
      fdl_q        <= fdl_d;
      under_q      <= under_d;
    end
  end

  // Line coder: eight-bit look-ahead so a zero run can be replaced
  // before its first bit leaves; latency is fixed either way.
  always_comb begin
    win    = {dat_q[6:0], stream_bit};
    dat_d  = win;
    pul_d  = {pul_q[6:0], 1'b0};
    vio_d  = {vio_q[6:0], 1'b0};
    mk_d   = {mk_q[6:0], st_q == TFO_ST_FBIT};
    pol_d  = pol_q;
    pos_d  = 1'b0;
    neg_d  = 1'b0;
    sync_d = mk_q[7];
    if (dat_q[7] || pul_q[7]) begin
      if (vio_q[7]) begin
        pos_d = pol_q;
        neg_d = !pol_q;
      end else begin
        pos_d = !pol_q;
        neg_d = pol_q;
        pol_d = !pol_q;
      end
    end
    if (ctl2_q[TFO_B2_B8ZS] && st_q != TFO_ST_IDLE && win == 8'h00 &&
        pul_d == 8'h00) begin
      pul_d = TFO_B8ZS_PULSE;
      vio_d = TFO_B8ZS_VIOL;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      dat_q  <= 8'h00;
      pul_q  <= 8'h00;
      vio_q  <= 8'h00;
      mk_q   <= 8'h00;
      pol_q  <= 1'b0;
      pos_q  <= 1'b0;
      neg_q  <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      dat_q  <= dat_d;
      pul_q  <= pul_d;
      vio_q  <= vio_d;
      mk_q   <= mk_d;
      pol_q  <= pol_d;
      pos_q  <= pos_d;
      neg_q  <= neg_d;
      sync_q <= sync_d;
    end
  end

  assign line_pos_out   = pos_q;
  assign line_neg_out   = neg_q;
  assign frame_sync_out = sync_q;
endmodule
`default_nettype wire

// [tfo_formatter_props.sv]
// Checker for the T1 transmit formatter, seeing only its top ports.
// Assumes D4 framing throughout; settings are shadowed from APB writes.
`timescale 1ns/1ps
`default_nettype none
module tfo_formatter_props
  import tfo_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // APB
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic        pready_out,
  input  wire logic        pslverr_out,
  // Stream and line
  input  wire logic        chan_ready_out,
  input  wire logic        transmit_serial_input_in,
  input  wire logic        line_pos_out,
  input  wire logic        line_neg_out,
  input  wire logic        frame_sync_out
);
  // cfg: 0 F pass, 1 yellow, 2 bit-7 stuff, 3 yellow format, 4 B8ZS seen
  logic       mark;
  logic [4:0] cfg_q, cfg_d;
  logic [8:0] stl_q, stl_d;
  logic [7:0] pos_q, pos_d;
  logic [6:0] hist_q, hist_d;
  logic       pol_q, pol_d;
  assign mark = line_pos_out | line_neg_out;
  always_comb begin
    cfg_d = cfg_q;
    stl_d = (stl_q == 9'h1FF) ? stl_q : stl_q + 9'h001;
    if (psel_in && penable_in && pready_out && pwrite_in) begin
      // Any write restarts the settle count, so stale line bits are skipped
      stl_d = 9'h000;
      if (paddr_in == TFO_OFF_CTRL_ONE) begin
        cfg_d[0] = pwdata_in[TFO_B1_FBIT_PASS];
        cfg_d[1] = pwdata_in[TFO_B1_YELLOW];
      end
      if (paddr_in == TFO_OFF_CTRL_TWO) begin
        cfg_d[2] = pwdata_in[TFO_B2_B7ZS];
        cfg_d[3] = pwdata_in[TFO_B2_D4YEL_FMT];
        cfg_d[4] = cfg_q[4] | pwdata_in[TFO_B2_B8ZS];
      end
    end
    pos_d  = frame_sync_out ? 8'h01 : pos_q + 8'h01;
    hist_d = {hist_q[5:0], mark};
    pol_d  = mark ? line_pos_out : pol_q;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_q  <= 5'h00;
      stl_q  <= 9'h000;
      pos_q  <= 8'h00;
      hist_q <= 7'h00;
      pol_q  <= 1'b0;
    end else begin
      cfg_q  <= cfg_d;
      stl_q  <= stl_d;
      pos_q  <= pos_d;
      hist_q <= hist_d;
      pol_q  <= pol_d;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_apb_wait;
    $rose(penable_in) && psel_in |-> !pready_out ##1 pready_out;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb wait wrong");
  property p_apb_err;
    pready_out && paddr_in[1:0] == 2'h0 |->
      pslverr_out == (paddr_in > TFO_OFF_STATUS);
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("pslverr wrong");
  property p_rst_out;
    disable iff (1'b0) rst_in |=> chan_ready_out && !pready_out && !mark;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset outputs");
  property p_frame;
    frame_sync_out |-> ##193 frame_sync_out;
  endproperty
  a_frame: assert property (p_frame) else $error("frame length wrong");
  property p_fpass;
    frame_sync_out && cfg_q[0] && !cfg_q[4] && stl_q > 9'h0C8 |->
      mark == $past(transmit_serial_input_in, 9);
  endproperty
  a_fpass: assert property (p_fpass)
    else $error("F bit not passed");
  property p_ami;
    mark && !cfg_q[4] |->
      (line_pos_out ^ line_neg_out) && line_pos_out != pol_q;
  endproperty
  a_ami: assert property (p_ami)
    else $error("polarity wrong");
  property p_yellow;
    cfg_q[1] && !cfg_q[3] && !cfg_q[4] && stl_q > 9'h0C8 &&
      pos_q[2:0] == 3'h2 |-> !mark;
  endproperty
  a_yellow: assert property (p_yellow)
    else $error("bit 2 not zero");
  property p_b7zs;
    cfg_q[2] && !cfg_q[4] && stl_q > 9'h0C8 && pos_q[2:0] == 3'h0 |->
      {hist_q, mark} != 8'h00;
  endproperty
  a_b7zs: assert property (p_b7zs)
    else $error("zero channel sent");
  c_err: cover property (pready_out && pslverr_out);
  c_fpass: cover property (frame_sync_out && cfg_q[0] && stl_q > 9'h0C8);
  c_yellow: cover property (cfg_q[1] && !cfg_q[3] && stl_q > 9'h0C8);
  c_b7zs: cover property (cfg_q[2] && stl_q > 9'h0C8);
endmodule
bind tfo_formatter tfo_formatter_props i_tfo_formatter_props (
  .clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .pready_out, .pslverr_out, .chan_ready_out,
  .transmit_serial_input_in, .line_pos_out, .line_neg_out, .frame_sync_out
);
`default_nettype wire

// [tfo_line_partner.sv]
// Remote terminal model: decodes the line, checks Ft bits, gathers Fs.
// Assumes D4 framing and that frame_sync marks each F bit on the line.
`timescale 1ns/1ps
`default_nettype none
module tfo_line_partner (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // Line
  input  wire logic       line_pos_in,
  input  wire logic       line_neg_in,
  input  wire logic       frame_sync_in,
  // Observations
  output logic      [7:0] ft_err_out,
  output logic      [7:0] viol_out,
  output logic      [5:0] fs_word_out,
  output logic      [7:0] f_ones_out
);
  logic [3:0] frm_q;
  logic       pol_q;
  logic       mark;
  assign mark = line_pos_in | line_neg_in;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      frm_q       <= 4'h0;
      pol_q       <= 1'b0;
      ft_err_out  <= 8'h00;
      viol_out    <= 8'h00;
      fs_word_out <= 6'h00;
      f_ones_out  <= 8'h00;
    end else begin
      if (mark) begin
        pol_q <= line_pos_in;
        if (line_pos_in == pol_q) viol_out <= viol_out + 8'h01;
      end
      if (frame_sync_in) begin
        frm_q <= (frm_q == 4'hB) ? 4'h0 : frm_q + 4'h1;
        // Marks among F bits, valid in any framing mode
        if (mark) f_ones_out <= f_ones_out + 8'h01;
        // Even frames carry 101010; odd frames fill the Fs word, frame 1 first
        if (!frm_q[0] && mark == frm_q[1]) ft_err_out <= ft_err_out + 8'h01;
        if (frm_q[0]) fs_word_out[3'h5 - frm_q[3:1]] <= mark;
      end
    end
  end
endmodule
`default_nettype wire

// [tfo_formatter_bench.sv]
// Self-checking bench for the T1 transmit formatter.
// Runs the design in D4 framing until the last test switches to ESF; the partner watches the line.
`timescale 1ns/1ps
`default_nettype none
module tfo_formatter_bench;
  import tfo_pkg::*;
  logic        clock_in   = 1'b0;
  logic        rst_in     = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [7:0]  chan_data  = 8'h00;
  logic        chan_valid = 1'b0;
  logic        ser        = 1'b0;
  logic [31:0] prdata, v;
  logic        pready, pslverr, chan_ready, line_pos, line_neg, fsync, err;
  logic [7:0]  ft_err, viol, b, f_ones;
  logic [5:0]  fs_word;
  int          err_count  = 0;
  int          cmp_count  = 0;
  always #20 clock_in = ~clock_in;
  tfo_formatter i_tfo_formatter (
    .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .chan_data_in(chan_data),
    .chan_valid_in(chan_valid), .chan_ready_out(chan_ready),
    .transmit_serial_input_in(ser), .line_pos_out(line_pos),
    .line_neg_out(line_neg), .frame_sync_out(fsync)
  );
  tfo_line_partner i_tfo_line_partner (
    .clock_in(clock_in), .rst_in(rst_in), .line_pos_in(line_pos),
    .line_neg_in(line_neg), .frame_sync_in(fsync),
    .ft_err_out(ft_err), .viol_out(viol), .fs_word_out(fs_word),
    .f_ones_out(f_ones)
  );
  task automatic final_report;
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    v   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000);
    compare(v, {24'h00_0000, e});
  endtask
  task automatic frames(input int n);
    repeat (n * 193) @(posedge clock_in);
  endtask
  initial begin
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rd_cmp(TFO_OFF_CTRL_ONE, TFO_RST_CTRL_ONE);
    rd_cmp(TFO_OFF_CTRL_TWO, TFO_RST_CTRL_TWO);
    rd_cmp(TFO_OFF_COMMON, TFO_RST_COMMON);
    rd_cmp(TFO_OFF_FACILITY, TFO_RST_FACILITY);
    rd_cmp(8'h20, 8'h00);
    compare(err, 1'b1);
    // Unused control-one bits must read back as zero
    apb(1'b1, TFO_OFF_CTRL_ONE, 32'h0000_00FF);
    rd_cmp(TFO_OFF_CTRL_ONE, TFO_MASK_CTRL_ONE);
    apb(1'b1, TFO_OFF_CTRL_ONE, 32'h0000_0000);
    // Nothing fed yet: the underrun count must saturate
    repeat (2400) @(posedge clock_in);
    apb(1'b0, TFO_OFF_STATUS, 32'h0000_0000);
    compare(v[15:8], 8'hFF);
    chan_valid <= 1'b1;
    chan_data  <= 8'hA5;
    repeat (20) if (chan_ready === 1'b1) @(posedge clock_in);
    compare(chan_ready, 1'b0);
    b = ft_err;
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0048);
    frames(8);
    compare(ft_err - b, 32'h0000_0003);
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0048);
    frames(8);
    compare(ft_err - b, 32'h0000_0003);
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0040);
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0048);
    frames(8);
    compare(ft_err - b, 32'h0000_0006);
    // One Ft bit in 128 is one in 256 frames: exactly one hit here
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0050);
    frames(260);
    compare(ft_err - b, 32'h0000_0007);
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0040);
    apb(1'b1, TFO_OFF_FACILITY, 32'h0000_002B);
    frames(26);
    compare(fs_word, 6'h2B);
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0004);
    apb(1'b1, TFO_OFF_CTRL_ONE, 32'h0000_0001);
    frames(26);
    compare(fs_word, {TFO_FS_PATTERN[5:1], 1'b1});
    chan_data <= 8'hFF;
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0000);
    frames(3);
    apb(1'b1, TFO_OFF_CTRL_ONE, 32'h0000_0000);
    frames(26);
    compare(fs_word, TFO_FS_PATTERN);
    chan_data <= 8'h00;
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0001);
    frames(3);
    ser <= 1'b1;
    apb(1'b1, TFO_OFF_CTRL_ONE, 32'h0000_0040);
    frames(4);
    ser <= 1'b0;
    apb(1'b1, TFO_OFF_CTRL_ONE, 32'h0000_0040);
    frames(4);
    apb(1'b1, TFO_OFF_CTRL_ONE, 32'h0000_0000);
    compare(viol, 8'h00);
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0080);
    frames(2);
    compare(viol != 8'h00, 1'b1);
    // ESF superframe: 12 FDL ones, 6 CRC bits from serial, FPS 001011
    ser <= 1'b1;
    apb(1'b1, TFO_OFF_CTRL_TWO, 32'h0000_0000);
    apb(1'b1, TFO_OFF_COMMON, 32'h0000_0001);
    apb(1'b1, TFO_OFF_CTRL_ONE, 32'h0000_0020);
    frames(1);
    b = f_ones;
    frames(24);
    compare(8'(f_ones - b), 8'd21);
    ser <= 1'b0;
    frames(1);
    b = f_ones;
    frames(24);
    compare(8'(f_ones - b), 8'd15);
    final_report;
  end
  initial begin
    repeat (95000) @(posedge clock_in);
    err_count++;
    final_report;
  end
endmodule
`default_nettype wire
